// ---- src/regset_pkg.sv ----
package regset_pkg;

  localparam int ADDR_W = 5;
  localparam int BANK_SLOTS = 7;

  localparam logic [4:0] IDX_R0 = 5'h00;
  localparam logic [4:0] IDX_R1 = 5'h01;
  localparam logic [4:0] IDX_R2 = 5'h02;
  localparam logic [4:0] IDX_R3 = 5'h03;
  localparam logic [4:0] IDX_A0 = 5'h04;
  localparam logic [4:0] IDX_A1 = 5'h05;
  localparam logic [4:0] IDX_FB = 5'h06;
  localparam logic [4:0] IDX_SB = 5'h07;
  localparam logic [4:0] IDX_VTB = 5'h08;
  localparam logic [4:0] IDX_PC = 5'h09;
  localparam logic [4:0] IDX_USP = 5'h0a;
  localparam logic [4:0] IDX_ISP = 5'h0b;
  localparam logic [4:0] IDX_FLG = 5'h0c;
  localparam logic [4:0] IDX_R0L = 5'h0d;
  localparam logic [4:0] IDX_R0H = 5'h0e;
  localparam logic [4:0] IDX_R1L = 5'h0f;
  localparam logic [4:0] IDX_R1H = 5'h10;
  localparam logic [4:0] IDX_LONG_DATA_PAIR_LOW = 5'h11;
  localparam logic [4:0] IDX_LONG_DATA_PAIR_HIGH = 5'h12;
  localparam logic [4:0] IDX_LONG_ADDRESS_PAIR = 5'h13;
  localparam logic [4:0] IDX_SP = 5'h14;

  localparam int FLAG_C = 0;
  localparam int FLAG_D = 1;
  localparam int FLAG_Z = 2;
  localparam int FLAG_S = 3;
  localparam int FLAG_B = 4;
  localparam int FLAG_O = 5;
  localparam int FLAG_I = 6;
  localparam int FLAG_U = 7;
  localparam int IPL_LSB = 12;
  localparam logic [15:0] FLG_WRITABLE = 16'h70ff;

  localparam logic [15:0] FLG_RESET = 16'h0000;
  localparam logic [15:0] WORD_RESET = 16'h0000;
  localparam logic [19:0] ADDR20_RESET = 20'h00000;
  localparam logic [5:0] SW_INT_SYS_MAX = 6'h1f;

  localparam logic [19:0] SFR_END = 20'h003ff;
  localparam logic [19:0] RAM_BASE = 20'h00400;
  localparam logic [19:0] SPECIAL_VEC_BASE = 20'hffe00;
  localparam logic [19:0] SPECIAL_VEC_END = 20'hfffdb;
  localparam logic [19:0] FIXED_VEC_BASE = 20'hfffdc;

  typedef enum logic [1:0] {
    SZ_BYTE = 2'h0,
    SZ_WORD = 2'h1,
    SZ_LONG = 2'h3
  } op_size_t;

  typedef enum logic [2:0] {
    REG_SFR = 3'h0,
    REG_MEMORY = 3'h1,
    REG_SPECIAL_VEC = 3'h2,
    REG_FIXED_VEC = 3'h3
  } region_t;

  typedef struct packed {
    logic valid;
    op_size_t size;
    logic [31:0] value;
    logic carry;
    logic overflow;
  } alu_result_t;

  typedef struct packed {
    logic hw_accept;
    logic sw_exec;
    logic [5:0] sw_num;
  } int_event_t;

endpackage : regset_pkg

// ---- src/cpu_register_set.sv ----
// Decided for this implementation: the plain strobed port and the address map.
`timescale 1ns/1ps
module cpu_register_set
  import regset_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata,
  input wire alu_result_t alu,
  input wire int_event_t ievt,
  input wire logic pc_load,
  input wire logic [19:0] pc_value,
  input wire logic [2:0] req_level,
  output logic [15:0] status_word,
  output logic [19:0] pc_out,
  output logic [19:0] vector_table_base,
  output logic [15:0] active_stack_pointer,
  output logic int_permit,
  output region_t pc_region
);

  // The two banks, then the shared registers outside the banks.
  logic [15:0] bank_reg [2][BANK_SLOTS];
  logic [15:0] static_base_reg;
  logic [19:0] vtb_reg;
  logic [19:0] pc_reg;
  logic [15:0] usp_reg;
  logic [15:0] isp_reg;
  logic [15:0] flg_reg;
  logic [31:0] rdata_reg;
  logic [15:0] sp_out_reg;
  logic permit_reg;
  region_t region_reg;

  logic [15:0] bank_next [2][BANK_SLOTS];
  logic [15:0] static_base_next;
  logic [19:0] vtb_next;
  logic [19:0] pc_next;
  logic [15:0] usp_next;
  logic [15:0] isp_next;
  logic [15:0] flg_next;
  logic [31:0] rdata_next;

  // Writes one bank slot from any word, byte or long view that covers it.
  function automatic logic [15:0] slot_write(
    input logic [15:0] cur,
    input logic [4:0] a,
    input int s,
    input logic [31:0] d
  );
    logic [15:0] v;
    v = cur;
    if (a == 5'(s)) begin
      v = d[15:0];
    end
    if ((s == 0 && a == IDX_R0L) || (s == 1 && a == IDX_R1L)) begin
      v[7:0] = d[7:0];
    end
    if ((s == 0 && a == IDX_R0H) || (s == 1 && a == IDX_R1H)) begin
      v[15:8] = d[7:0];
    end
    if ((s == 0 && a == IDX_LONG_DATA_PAIR_LOW) || (s == 1 && a == IDX_LONG_DATA_PAIR_HIGH) ||
        (s == 4 && a == IDX_LONG_ADDRESS_PAIR)) begin
      v = d[15:0];
    end
    if ((s == 2 && a == IDX_LONG_DATA_PAIR_LOW) || (s == 3 && a == IDX_LONG_DATA_PAIR_HIGH) ||
        (s == 5 && a == IDX_LONG_ADDRESS_PAIR)) begin
      v = d[31:16];
    end
    return v;
  endfunction : slot_write

  function automatic region_t region_of(input logic [19:0] a);
    region_t r;
    r = REG_MEMORY;
    if (a <= SFR_END) begin
      r = REG_SFR;
    end else if (a >= FIXED_VEC_BASE) begin
      r = REG_FIXED_VEC;
    end else if (a >= SPECIAL_VEC_BASE && a <= SPECIAL_VEC_END) begin
      r = REG_SPECIAL_VEC;
    end
    return r;
  endfunction : region_of

  function automatic logic result_zero(input alu_result_t r);
    logic z;
    case (r.size)
      SZ_BYTE: z = (r.value[7:0] == 8'h00);
      SZ_WORD: z = (r.value[15:0] == 16'h0000);
      default: z = (r.value == 32'h0000_0000);
    endcase
    return z;
  endfunction : result_zero

  function automatic logic result_sign(input alu_result_t r);
    logic s;
    case (r.size)
      SZ_BYTE: s = r.value[7];
      SZ_WORD: s = r.value[15];
      default: s = r.value[31];
    endcase
    return s;
  endfunction : result_sign

  wire bank_sel = flg_reg[FLAG_B];
  wire sp_sel = flg_reg[FLAG_U];
  wire [2:0] processor_priority_level = flg_reg[IPL_LSB +: 3];

  wire wr_sb = wr && addr == IDX_SB;
  wire wr_vtb = wr && addr == IDX_VTB;
  wire wr_pc = wr && addr == IDX_PC;
  wire wr_usp = wr && (addr == IDX_USP || (addr == IDX_SP && sp_sel));
  wire wr_isp = wr && (addr == IDX_ISP || (addr == IDX_SP && !sp_sel));
  wire wr_flg = wr && addr == IDX_FLG;

  // Only the selected bank takes a write; the other keeps its contents.
  genvar gb, gs;
  generate
    for (gb = 0; gb < 2; gb++) begin : g_bank
      for (gs = 0; gs < BANK_SLOTS; gs++) begin : g_slot
        assign bank_next[gb][gs] =
          (wr && bank_sel == 1'(gb)) ?
          slot_write(bank_reg[gb][gs], addr, gs, wdata) :
          bank_reg[gb][gs];
      end
    end
  endgenerate

  // A bank switch touches none of these.
  assign static_base_next = wr_sb ? wdata[15:0] : static_base_reg;
  assign vtb_next = wr_vtb ? wdata[19:0] : vtb_reg;
  assign usp_next = wr_usp ? wdata[15:0] : usp_reg;
  assign isp_next = wr_isp ? wdata[15:0] : isp_reg;

  // The sequencer load outranks a software write in the same cycle.
  assign pc_next = pc_load ? pc_value :
                   wr_pc ? wdata[19:0] : pc_reg;

  wire sw_sys = ievt.sw_exec && ievt.sw_num <= SW_INT_SYS_MAX;
  wire any_accept = ievt.hw_accept || ievt.sw_exec;

  // Software writes first, then the ALU result, then interrupt entry, so
  // hardware events always win over a write landing in the same cycle.
  // Reserved bits are forced to zero, which is one legal undefined value.
  wire [15:0] flg_sw = wr_flg ? (wdata[15:0] & FLG_WRITABLE) :
                       flg_reg;

  always_comb begin
    flg_next = flg_sw;
    if (alu.valid) begin
      flg_next[FLAG_C] = alu.carry;
      flg_next[FLAG_Z] = result_zero(alu);
      flg_next[FLAG_S] = result_sign(alu);
      flg_next[FLAG_O] = alu.overflow;
    end
    if (any_accept) begin
      flg_next[FLAG_I] = 1'b0;
    end
    if (ievt.hw_accept || sw_sys) begin
      flg_next[FLAG_U] = 1'b0;
    end
  end

  wire [15:0] cur_sp = sp_sel ? usp_reg : isp_reg;

  function automatic logic [31:0] read_mux(
    input logic [4:0] a,
    input logic [15:0] b0,
    input logic [15:0] b1,
    input logic [15:0] b2,
    input logic [15:0] b3,
    input logic [15:0] b4,
    input logic [15:0] b5,
    input logic [15:0] b6
  );
    logic [31:0] v;
    case (a)
      IDX_R0: v = {16'h0000, b0};
      IDX_R1: v = {16'h0000, b1};
      IDX_R2: v = {16'h0000, b2};
      IDX_R3: v = {16'h0000, b3};
      IDX_A0: v = {16'h0000, b4};
      IDX_A1: v = {16'h0000, b5};
      IDX_FB: v = {16'h0000, b6};
      IDX_R0L: v = {24'h000000, b0[7:0]};
      IDX_R0H: v = {24'h000000, b0[15:8]};
      IDX_R1L: v = {24'h000000, b1[7:0]};
      IDX_R1H: v = {24'h000000, b1[15:8]};
      IDX_LONG_DATA_PAIR_LOW: v = {b2, b0};
      IDX_LONG_DATA_PAIR_HIGH: v = {b3, b1};
      IDX_LONG_ADDRESS_PAIR: v = {b5, b4};
      default: v = 32'h0000_0000;
    endcase
    return v;
  endfunction : read_mux

  wire [31:0] bank_rd = read_mux(addr,
    bank_reg[bank_sel][0], bank_reg[bank_sel][1],
    bank_reg[bank_sel][2], bank_reg[bank_sel][3],
    bank_reg[bank_sel][4], bank_reg[bank_sel][5],
    bank_reg[bank_sel][6]);

  wire [31:0] shared_rd =
    (addr == IDX_SB) ? {16'h0000, static_base_reg} :
    (addr == IDX_VTB) ? {12'h000, vtb_reg} :
    (addr == IDX_PC) ? {12'h000, pc_reg} :
    (addr == IDX_USP) ? {16'h0000, usp_reg} :
    (addr == IDX_ISP) ? {16'h0000, isp_reg} :
    (addr == IDX_SP) ? {16'h0000, cur_sp} :
    (addr == IDX_FLG) ? {16'h0000, flg_reg} :
    bank_rd;

  // Read data stand for exactly one cycle; unmapped addresses read zero.
  assign rdata_next = rd ? shared_rd : 32'h0000_0000;

  // The next stack pointer follows the next stack select flag, so a hardware
  // accept or a software interrupt up to SW_INT_SYS_MAX shows the interrupt pointer one cycle after the event.
  wire [15:0] sp_next = flg_next[FLAG_U] ? usp_next : isp_next;

  // Compared against the present level; a level change takes effect on
  // the following comparison, costing one cycle of latency.
  wire permit_next = flg_reg[FLAG_I] && (req_level > processor_priority_level);

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      for (int b = 0; b < 2; b++) begin
        for (int s = 0; s < BANK_SLOTS; s++) begin
          bank_reg[b][s] <= WORD_RESET;
        end
      end
    end else begin
      for (int b = 0; b < 2; b++) begin
        for (int s = 0; s < BANK_SLOTS; s++) begin
          bank_reg[b][s] <= bank_next[b][s];
        end
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      static_base_reg <= WORD_RESET;
      vtb_reg <= ADDR20_RESET;
      pc_reg <= ADDR20_RESET;
      usp_reg <= WORD_RESET;
      isp_reg <= WORD_RESET;
      flg_reg <= FLG_RESET;
    end else begin
      static_base_reg <= static_base_next;
      vtb_reg <= vtb_next;
      pc_reg <= pc_next;
      usp_reg <= usp_next;
      isp_reg <= isp_next;
      flg_reg <= flg_next;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rdata_reg <= 32'h0000_0000;
      sp_out_reg <= WORD_RESET;
      permit_reg <= 1'b0;
      region_reg <= REG_SFR;
    end else begin
      rdata_reg <= rdata_next;
      sp_out_reg <= sp_next;
      permit_reg <= permit_next;
      region_reg <= region_of(pc_next);
    end
  end

  assign rdata = rdata_reg;
  assign status_word = flg_reg;
  assign pc_out = pc_reg;
  assign vector_table_base = vtb_reg;
  assign active_stack_pointer = sp_out_reg;
  assign int_permit = permit_reg;
  assign pc_region = region_reg;

endmodule : cpu_register_set

// ---- bench/regset_sva.sv ----
`timescale 1ns/1ps
module regset_sva
  import regset_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic rd,
  input wire logic [31:0] rdata,
  input wire alu_result_t alu,
  input wire int_event_t ievt,
  input wire logic pc_load,
  input wire logic [19:0] pc_value,
  input wire logic [2:0] req_level,
  input wire logic [15:0] status_word,
  input wire logic [19:0] pc_out,
  input wire logic int_permit
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);
  // Zero and sign are judged only on the bits that the operand size covers.
  wire logic z_exp = (alu.size == SZ_BYTE) ? (alu.value[7:0] == 8'h00) :
    (alu.size == SZ_WORD) ? (alu.value[15:0] == 16'h0000) :
    (alu.value == 32'h0);
  wire logic s_exp = (alu.size == SZ_BYTE) ? alu.value[7] :
    (alu.size == SZ_WORD) ? alu.value[15] : alu.value[31];
  a_read_idle: assert property (!rd |=> rdata == 32'h0)
    else $error("read data not idle");
  a_carry_track: assert property (
    alu.valid |=> status_word[FLAG_C] == $past(alu.carry))
    else $error("carry flag wrong");
  a_ovf_track: assert property (
    alu.valid |=> status_word[FLAG_O] == $past(alu.overflow))
    else $error("overflow flag wrong");
  a_zero_track: assert property (
    alu.valid |=> status_word[FLAG_Z] == $past(z_exp))
    else $error("zero flag wrong");
  a_sign_track: assert property (
    alu.valid |=> status_word[FLAG_S] == $past(s_exp))
    else $error("sign flag wrong");
  a_hw_clear: assert property (
    ievt.hw_accept |=> !status_word[FLAG_I] && !status_word[FLAG_U])
    else $error("hardware accept left flags set");
  a_sw_clear: assert property (
    ievt.sw_exec && ievt.sw_num <= SW_INT_SYS_MAX |=>
      !status_word[FLAG_U] && !status_word[FLAG_I])
    else $error("software interrupt left flags set");
  a_permit_gate: assert property (
    1'b1 |=> int_permit == ($past(status_word[FLAG_I]) &&
      ($past(req_level) > $past(status_word[14:12]))))
    else $error("permit does not follow enable and level");
  a_pc_load: assert property (pc_load |=> pc_out == $past(pc_value))
    else $error("program counter load lost");
  a_reserved_zero: assert property (
    status_word[11:8] == 4'h0 && !status_word[15])
    else $error("reserved status bits set");
  c_hw: cover property (ievt.hw_accept);
  c_sw: cover property (ievt.sw_exec);
  c_permit: cover property (int_permit);
endmodule : regset_sva

// ---- bench/datapath_model.sv ----
`timescale 1ns/1ps
module datapath_model
  import regset_pkg::*;
(
  input wire logic clk,
  output alu_result_t alu,
  output int_event_t ievt,
  output logic pc_load,
  output logic [19:0] pc_value,
  output logic [2:0] req_level
);
  initial begin
    alu = '0;
    ievt = '0;
    pc_load = 1'b0;
    pc_value = 20'h0;
    req_level = 3'h0;
  end
  // Each ALU, interrupt and PC load event is a one-cycle pulse so none is ever taken twice; set_level holds its level.
  task automatic alu_op(input op_size_t sz, input logic [31:0] v,
                        input logic c, input logic o);
    @(posedge clk);
    alu <= '{1'b1, sz, v, c, o};
    @(posedge clk);
    alu.valid <= 1'b0;
  endtask : alu_op
  task automatic int_ev(input logic hw, input logic [5:0] n);
    @(posedge clk);
    ievt <= '{hw, !hw, n};
    @(posedge clk);
    ievt <= '0;
  endtask : int_ev
  task automatic load_pc(input logic [19:0] v);
    @(posedge clk);
    pc_load <= 1'b1;
    pc_value <= v;
    @(posedge clk);
    pc_load <= 1'b0;
  endtask : load_pc
  task automatic set_level(input logic [2:0] l);
    @(posedge clk);
    req_level <= l;
  endtask : set_level
endmodule : datapath_model

// ---- bench/cpu_register_set_and_flags_bench.sv ----
`timescale 1ns/1ps
`define CHK(got, exp) \
  begin \
    samples_checked++; \
    if ((got) !== (exp)) begin \
      n_mismatch++; \
      $display("mismatch at %0t: got %h want %h", $time, got, exp); \
    end \
  end
module cpu_register_set_and_flags_bench
  import regset_pkg::*;
;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic [4:0] addr = 5'h0;
  logic [31:0] wdata = 32'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [31:0] rdata;
  alu_result_t alu;
  int_event_t ievt;
  logic pc_load;
  logic [19:0] pc_value, pc_out, vector_table_base;
  logic [2:0] req_level;
  logic [15:0] status_word, active_stack_pointer;
  logic int_permit;
  region_t pc_region;
  int n_mismatch = 0;
  int samples_checked = 0;
  always #2.5 clk = ~clk;
  cpu_register_set u_cpu_register_set(.clk(clk), .rstn(rstn), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .alu(alu), .ievt(ievt),
    .pc_load(pc_load), .pc_value(pc_value), .req_level(req_level),
    .status_word(status_word), .pc_out(pc_out),
    .vector_table_base(vector_table_base),
    .active_stack_pointer(active_stack_pointer), .int_permit(int_permit),
    .pc_region(pc_region));
  datapath_model u_datapath_model(.clk(clk), .alu(alu), .ievt(ievt),
    .pc_load(pc_load), .pc_value(pc_value), .req_level(req_level));
  task automatic wr_reg(input logic [4:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg
  task automatic rd_chk(input logic [4:0] a, input logic [31:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    `CHK(rdata, e)
  endtask : rd_chk
  task automatic alu_chk(input op_size_t sz, input logic [31:0] v,
                         input logic c, input logic o, input logic [15:0] e);
    u_datapath_model.alu_op(sz, v, c, o);
    @(negedge clk);
    `CHK(status_word, e)
  endtask : alu_chk
  function automatic logic [31:0] val(int b, int i);
    return 32'ha000 + 32'(b * 256 + i * 17);
  endfunction : val
  task automatic results();
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : results
  initial begin
    #20000;
    n_mismatch++;
    results();
  end
  initial begin
    logic [19:0] pcs [5] = '{20'h003ff, 20'h00400, 20'hffe00, 20'hfffdb,
                             20'hfffdc};
    region_t regs [5] = '{REG_SFR, REG_MEMORY, REG_SPECIAL_VEC,
                          REG_SPECIAL_VEC, REG_FIXED_VEC};
    repeat (6) @(posedge clk);
    rstn <= 1'b1;
    for (int i = 0; i <= 21; i++) rd_chk(i[4:0], 32'h0);
    for (int i = 0; i < 7; i++) wr_reg(i[4:0], 32'hdead0000 | val(0, i));
    wr_reg(IDX_SB, 32'hdead5b5b);
    wr_reg(IDX_VTB, 32'hffffffff);
    wr_reg(IDX_PC, 32'hfff12345);
    wr_reg(IDX_USP, 32'h7777);
    wr_reg(IDX_ISP, 32'h6666);
    wr_reg(IDX_FLG, 32'h0010);
    for (int i = 0; i < 7; i++) rd_chk(i[4:0], 32'h0);
    for (int i = 0; i < 7; i++) wr_reg(i[4:0], val(1, i));
    rd_chk(IDX_SB, 32'h5b5b);
    rd_chk(IDX_VTB, 32'hfffff);
    rd_chk(IDX_PC, 32'h12345);
    `CHK(vector_table_base, 20'hfffff)
    rd_chk(IDX_SP, 32'h6666);
    wr_reg(IDX_FLG, 32'h0090);
    rd_chk(IDX_SP, 32'h7777);
    `CHK(active_stack_pointer, 16'h7777)
    for (int i = 0; i < 7; i++) rd_chk(i[4:0], val(1, i));
    wr_reg(IDX_FLG, 32'h0);
    for (int i = 0; i < 7; i++) rd_chk(i[4:0], val(0, i));
    rd_chk(IDX_R0H, 32'ha0);
    rd_chk(IDX_R1L, 32'h11);
    rd_chk(IDX_LONG_DATA_PAIR_LOW, 32'ha022a000);
    rd_chk(IDX_LONG_DATA_PAIR_HIGH, 32'ha033a011);
    rd_chk(IDX_LONG_ADDRESS_PAIR, 32'ha055a044);
    wr_reg(IDX_R0L, 32'h5a);
    rd_chk(IDX_R0, 32'ha05a);
    wr_reg(IDX_LONG_DATA_PAIR_HIGH, 32'h87654321);
    rd_chk(IDX_R3, 32'h8765);
    rd_chk(IDX_R1, 32'h4321);
    // The debug flag stays clear even while the reserved bits are hammered.
    wr_reg(IDX_FLG, 32'hfffd);
    rd_chk(IDX_FLG, 32'h70fd);
    wr_reg(IDX_FLG, 32'h0);
    alu_chk(SZ_WORD, 32'h00008000, 1'b1, 1'b0, 16'h0009);
    alu_chk(SZ_BYTE, 32'h00000100, 1'b0, 1'b1, 16'h0024);
    alu_chk(SZ_LONG, 32'h80000000, 1'b0, 1'b0, 16'h0008);
    alu_chk(SZ_LONG, 32'h00000000, 1'b1, 1'b1, 16'h0025);
    alu_chk(SZ_BYTE, 32'h0000007f, 1'b0, 1'b0, 16'h0000);
    wr_reg(IDX_FLG, 32'h30c0);
    u_datapath_model.set_level(3'h4);
    repeat (2) @(posedge clk);
    @(negedge clk);
    `CHK(int_permit, 1'b1)
    u_datapath_model.set_level(3'h3);
    repeat (2) @(posedge clk);
    @(negedge clk);
    `CHK(int_permit, 1'b0)
    u_datapath_model.int_ev(1'b1, 6'h0);
    @(negedge clk);
    `CHK(status_word, 16'h3000)
    wr_reg(IDX_FLG, 32'h30c0);
    u_datapath_model.int_ev(1'b0, 6'h20);
    @(negedge clk);
    `CHK(status_word, 16'h3080)
    u_datapath_model.int_ev(1'b0, 6'h1f);
    @(negedge clk);
    `CHK(status_word, 16'h3000)
    for (int i = 0; i < 5; i++) begin
      u_datapath_model.load_pc(pcs[i]);
      repeat (2) @(posedge clk);
      @(negedge clk);
      `CHK(pc_out, pcs[i])
      `CHK(pc_region, regs[i])
    end
    // A reset in mid-run clears banked and shared registers alike.
    @(posedge clk);
    rstn <= 1'b0;
    repeat (2) @(posedge clk);
    @(negedge clk);
    `CHK(pc_out, ADDR20_RESET)
    `CHK(pc_region, REG_SFR)
    `CHK(vector_table_base, ADDR20_RESET)
    `CHK(active_stack_pointer, WORD_RESET)
    `CHK(status_word, FLG_RESET)
    @(posedge clk);
    rstn <= 1'b1;
    rd_chk(IDX_LONG_DATA_PAIR_LOW, 32'h0);
    rd_chk(IDX_SB, 32'h0);
    rd_chk(IDX_USP, 32'h0);
    results();
  end
endmodule : cpu_register_set_and_flags_bench
bind cpu_register_set regset_sva u_regset_sva(.clk(clk), .rstn(rstn),
  .rd(rd), .rdata(rdata), .alu(alu), .ievt(ievt), .pc_load(pc_load),
  .pc_value(pc_value), .req_level(req_level), .status_word(status_word),
  .pc_out(pc_out), .int_permit(int_permit));
